// ### verilog/qgp_top.sv
// quad general-purpose port block with wishbone register access and pin sharing
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module qgp_top
   import qgp_pkg::*;
(
   input  wire logic              clk_in,
   input  wire logic              reset_n_in,
   input  wire logic              wb_cyc_in,
   input  wire logic              wb_stb_in,
   input  wire logic              wb_we_in,
   input  wire logic [QGP_AW-1:0] wb_adr_in,
   input  wire logic [3:0]        wb_sel_in,
   input  wire logic [31:0]       wb_dat_in,
   output logic      [31:0]       wb_dat_out,
   output logic                   wb_ack_out,
   input  wire logic [7:0]        pa_pin_in,
   output logic      [7:0]        pa_pin_out,
   output logic      [7:0]        pa_pin_oe_n_out,
   input  wire logic [5:0]        pb_pin_in,
   output logic      [5:0]        pb_pin_out,
   output logic      [5:0]        pb_pin_oe_n_out,
   input  wire logic [7:0]        pc_pin_in,
   output logic      [7:0]        pc_pin_out,
   output logic      [7:0]        pc_pin_oe_n_out,
   input  wire logic [3:0]        pd_pin_in,
   output logic      [3:0]        pd_pin_out,
   output logic      [3:0]        pd_pin_oe_n_out,
   input  wire logic [7:0]        pwm_in,
   input  wire logic              vsync_src_in,
   input  wire logic              hsync_src_in,
   input  wire logic              clamp_src_in,
   input  wire logic              sda_drive_low_in,
   input  wire logic              scl_drive_low_in,
   output logic                   sda_level_out,
   output logic                   scl_level_out,
   output logic      [3:0]        adc_channel_select_out,
   output logic                   green_sync_level_out
);

   // ****************************************
   // registers
   // ****************************************
   logic [7:0]  a_lat_r;
   logic [7:0]  b_lat_r;
   logic [7:0]  c_lat_r;
   logic [7:0]  d_lat_r;
   logic [7:0]  a_dir_r;
   logic [7:0]  b_dir_r;
   logic [7:0]  c_dir_r;
   logic [7:0]  d_dir_r;
   logic [7:0]  alt_function_config_first_r;
   logic [7:0]  alt_function_config_second_r;
   logic [7:0]  sync_pin_io_control_r;
   logic [25:0] pin_s1_r;
   logic [25:0] pin_s2_r;
   logic [7:0]  a_in;
   logic [7:0]  b_in;
   logic [7:0]  c_in;
   logic [7:0]  d_in;
   logic        req;
   logic        aligned;
   logic        wr_en;
   logic [3:0]  idx;
   logic [7:0]  wdat;
   logic [7:0]  rd_nxt;
   logic        hit;

   assign idx     = wb_adr_in[5:2];
   assign wdat    = wb_dat_in[7:0];
   assign req     = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   // an access off the word boundary is acked but must never reach a register
   assign aligned = (wb_adr_in[1:0] == 2'b00);
   assign wr_en   = req & wb_we_in & wb_sel_in[0] & aligned;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pin_s1_r <= {pd_pin_in, pc_pin_in, pb_pin_in, pa_pin_in};
         pin_s2_r <= pin_s1_r;
      end
   end

   assign a_in = pin_s2_r[7:0];
   assign b_in = {2'b00, pin_s2_r[13:8]};
   assign c_in = pin_s2_r[21:14];
   assign d_in = {4'h0, pin_s2_r[25:22]};

   // ****************************************
   // data latches
   // ****************************************
   // no reset here: latch contents survive a reset, so software can preload
   // the level a pin will show before it turns the pin into an output
   always_ff @(posedge clk_in) begin
      if (wr_en && idx == QGP_IDX_A_DATA) begin
         a_lat_r <= wdat;
      end
   end

   always_ff @(posedge clk_in) begin
      if (wr_en && idx == QGP_IDX_B_DATA) begin
         b_lat_r <= wdat & QGP_MASK_B;
      end
   end

   always_ff @(posedge clk_in) begin
      if (wr_en && idx == QGP_IDX_C_DATA) begin
         c_lat_r <= wdat;
      end
   end

   always_ff @(posedge clk_in) begin
      if (wr_en && idx == QGP_IDX_D_DATA) begin
         d_lat_r <= wdat & QGP_MASK_D;
      end
   end

   // ****************************************
   // direction and configuration
   // ****************************************
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         a_dir_r <= QGP_DIR_RST;
      end else if (wr_en && idx == QGP_IDX_A_DIR) begin
         a_dir_r <= wdat;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         b_dir_r <= QGP_DIR_RST;
      end else if (wr_en && idx == QGP_IDX_B_DIR) begin
         b_dir_r <= wdat & QGP_MASK_B;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         c_dir_r <= QGP_DIR_RST;
      end else if (wr_en && idx == QGP_IDX_C_DIR) begin
         c_dir_r <= wdat;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         d_dir_r <= QGP_DIR_RST;
      end else if (wr_en && idx == QGP_IDX_D_DIR) begin
         d_dir_r <= wdat & QGP_MASK_D;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         alt_function_config_first_r  <= QGP_CFG_RST;
         alt_function_config_second_r <= QGP_CFG_RST;
         sync_pin_io_control_r        <= QGP_CFG_RST;
      end else if (wr_en) begin
         case (idx)
            QGP_IDX_CFG1: alt_function_config_first_r  <= wdat;
            QGP_IDX_CFG2: alt_function_config_second_r <= wdat;
            QGP_IDX_SPIO: sync_pin_io_control_r        <= wdat & 8'h03;
            default: ;
         endcase
      end
   end

   // ****************************************
   // wishbone read and acknowledge
   // ****************************************
   // a pin reads its latch when its direction bit is set, else its sampled level
   always_comb begin
      hit    = 1'b1;
      rd_nxt = 8'h00;
      case (idx)
         QGP_IDX_A_DATA: rd_nxt = (a_dir_r & a_lat_r) | (~a_dir_r & a_in);
         QGP_IDX_B_DATA: rd_nxt = ((b_dir_r & b_lat_r) | (~b_dir_r & b_in)) & QGP_MASK_B;
         QGP_IDX_C_DATA: rd_nxt = (c_dir_r & c_lat_r) | (~c_dir_r & c_in);
         QGP_IDX_D_DATA: rd_nxt = ((d_dir_r & d_lat_r) | (~d_dir_r & d_in)) & QGP_MASK_D;
         QGP_IDX_A_DIR:  rd_nxt = a_dir_r;
         QGP_IDX_B_DIR:  rd_nxt = b_dir_r;
         QGP_IDX_C_DIR:  rd_nxt = c_dir_r;
         QGP_IDX_D_DIR:  rd_nxt = d_dir_r;
         QGP_IDX_CFG1:   rd_nxt = alt_function_config_first_r;
         QGP_IDX_CFG2:   rd_nxt = alt_function_config_second_r;
         QGP_IDX_SPIO:   rd_nxt = sync_pin_io_control_r;
         default:        hit    = 1'b0;
      endcase
      if (!hit || wb_adr_in[1:0] != 2'b00) rd_nxt = 8'h00;
   end

   // unmapped addresses still ack, reading zero and dropping writes
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
         wb_dat_out <= {24'h000000, rd_nxt};
      end
   end

   // ****************************************
   // pin drive
   // ****************************************
   logic [7:0] c_out_nxt;
   logic [7:0] c_oe_n_nxt;
   logic [3:0] d_out_nxt;
   logic [3:0] d_oe_n_nxt;
   logic [7:0] c_sel2;

   // pins 7..2 of port c have second-register functions, which win
   assign c_sel2 = {alt_function_config_second_r[7:2], 2'b00};

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pc
         always_comb begin
            if (c_sel2[gi]) begin
               if (gi == QGP_CFG2_HSYN) begin
                  c_out_nxt[gi]  = hsync_src_in;
                  c_oe_n_nxt[gi] = 1'b0;
               end else if (gi == QGP_CFG2_VSYN) begin
                  c_out_nxt[gi]  = vsync_src_in;
                  c_oe_n_nxt[gi] = 1'b0;
               end else begin
                  c_out_nxt[gi]  = 1'b0;
                  c_oe_n_nxt[gi] = 1'b1;
               end
            end else if (alt_function_config_first_r[gi]) begin
               c_out_nxt[gi]  = pwm_in[gi];
               c_oe_n_nxt[gi] = 1'b0;
            end else begin
               c_out_nxt[gi]  = c_lat_r[gi];
               c_oe_n_nxt[gi] = ~c_dir_r[gi];
            end
         end
      end
   endgenerate

   always_comb begin
      d_out_nxt  = d_lat_r[3:0];
      d_oe_n_nxt = ~d_dir_r[3:0];
      // serial bus pins are open drain: drive low or release
      if (alt_function_config_second_r[QGP_CFG2_SDA]) begin
         d_out_nxt[0]  = 1'b0;
         d_oe_n_nxt[0] = ~sda_drive_low_in;
      end
      if (alt_function_config_second_r[QGP_CFG2_SCL]) begin
         d_out_nxt[1]  = 1'b0;
         d_oe_n_nxt[1] = ~scl_drive_low_in;
      end
      if (sync_pin_io_control_r[QGP_SPIO_CLAMP]) begin
         d_out_nxt[2]  = clamp_src_in;
         d_oe_n_nxt[2] = 1'b0;
      end
      if (sync_pin_io_control_r[QGP_SPIO_SOG]) begin
         d_out_nxt[3]  = 1'b0;
         d_oe_n_nxt[3] = 1'b1;
      end
   end

   // ****************************************
   // registered pin drive
   // ****************************************

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pa_pin_out      <= '0;
         pa_pin_oe_n_out <= '1;
      end else begin
         pa_pin_out      <= a_lat_r;
         pa_pin_oe_n_out <= ~a_dir_r;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pb_pin_out      <= '0;
         pb_pin_oe_n_out <= '1;
      end else begin
         pb_pin_out      <= b_lat_r[5:0];
         pb_pin_oe_n_out <= ~b_dir_r[5:0];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_pin_out      <= '0;
         pc_pin_oe_n_out <= '1;
      end else begin
         pc_pin_out      <= c_out_nxt;
         pc_pin_oe_n_out <= c_oe_n_nxt;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pd_pin_out      <= '0;
         pd_pin_oe_n_out <= '1;
      end else begin
         pd_pin_out      <= d_out_nxt;
         pd_pin_oe_n_out <= d_oe_n_nxt;
      end
   end

   // ****************************************
   // alternate function inputs
   // ****************************************
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sda_level_out <= 1'b1;
      end else begin
         // idle high while the serial block does not own the pin, like a released line
         sda_level_out <= alt_function_config_second_r[QGP_CFG2_SDA] ? d_in[0] : 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         scl_level_out <= 1'b1;
      end else begin
         scl_level_out <= alt_function_config_second_r[QGP_CFG2_SCL] ? d_in[1] : 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         adc_channel_select_out <= '0;
      end else begin
         adc_channel_select_out <= alt_function_config_second_r[QGP_CFG2_ADC0 +: 4];
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         green_sync_level_out <= 1'b0;
      end else begin
         green_sync_level_out <= sync_pin_io_control_r[QGP_SPIO_SOG] & d_in[3];
      end
   end

endmodule
`default_nettype wire

// ### shared/qgp_pkg.sv
// constants for the quad general-purpose port block with alternate pin functions
package qgp_pkg;
   localparam int unsigned QGP_AW = 6;
   // register indexes; byte address is four times the index
   localparam logic [3:0] QGP_IDX_A_DATA = 4'h0;
   localparam logic [3:0] QGP_IDX_B_DATA = 4'h1;
   localparam logic [3:0] QGP_IDX_C_DATA = 4'h2;
   localparam logic [3:0] QGP_IDX_D_DATA = 4'h3;
   localparam logic [3:0] QGP_IDX_A_DIR  = 4'h4;
   localparam logic [3:0] QGP_IDX_B_DIR  = 4'h5;
   localparam logic [3:0] QGP_IDX_C_DIR  = 4'h6;
   localparam logic [3:0] QGP_IDX_D_DIR  = 4'h7;
   localparam logic [3:0] QGP_IDX_CFG1   = 4'h8;
   localparam logic [3:0] QGP_IDX_CFG2   = 4'h9;
   localparam logic [3:0] QGP_IDX_SPIO   = 4'ha;
   // implemented bits per port
   localparam logic [7:0] QGP_MASK_B     = 8'h3f;
   localparam logic [7:0] QGP_MASK_D     = 8'h0f;
   // second config register fields
   localparam int unsigned QGP_CFG2_SDA  = 0;
   localparam int unsigned QGP_CFG2_SCL  = 1;
   localparam int unsigned QGP_CFG2_ADC0 = 2;
   localparam int unsigned QGP_CFG2_VSYN = 6;
   localparam int unsigned QGP_CFG2_HSYN = 7;
   // sync pin io control fields
   localparam int unsigned QGP_SPIO_CLAMP = 0;
   localparam int unsigned QGP_SPIO_SOG   = 1;
   // reset values
   localparam logic [7:0] QGP_DIR_RST    = 8'h00;
   localparam logic [7:0] QGP_CFG_RST    = 8'h00;
endpackage

// ### sim/qgp_top_sva.sv
// assertion checker for the quad port block, seeing only its ports
`timescale 1ns/1ps
`default_nettype none
module qgp_sva (
   input wire logic        clk_in,
   input wire logic        reset_n_in,
   input wire logic        wb_cyc_in,
   input wire logic        wb_stb_in,
   input wire logic        wb_we_in,
   input wire logic [5:0]  wb_adr_in,
   input wire logic [3:0]  wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic        wb_ack_out,
   input wire logic [7:0]  pa_pin_oe_n_out,
   input wire logic [7:0]  pc_pin_out,
   input wire logic [7:0]  pc_pin_oe_n_out,
   input wire logic [7:0]  pwm_in
);
   logic [7:0] shadow_r [0:15];
   logic       take;
   logic [3:0] idx;
   assign take = wb_cyc_in && wb_stb_in && !wb_ack_out && wb_adr_in[1:0] == 2'h0;
   assign idx = wb_adr_in[5:2];
   // mirror of the registers; data latches are left alone by reset, like the block's
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 4; i < 16; i++) shadow_r[i] <= 8'h00;
      end else if (take && wb_we_in && wb_sel_in[0]) begin
         shadow_r[idx] <= wb_dat_in[7:0];
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   property p_ack; take |=> wb_ack_out ##1 !wb_ack_out; endproperty
   a_ack: assert property (p_ack) else $error("ack not one pulse");
   property p_rst; $rose(reset_n_in) |-> &pa_pin_oe_n_out && &pc_pin_oe_n_out; endproperty
   a_rst: assert property (p_rst) else $error("pin driven after reset");
   property p_dir_a; pa_pin_oe_n_out == ~$past(shadow_r[4]); endproperty
   a_dir_a: assert property (p_dir_a) else $error("port a enable wrong");
   property p_dir_c; $past(shadow_r[8]) == 8'h00 && $past(shadow_r[9]) == 8'h00
      |-> pc_pin_oe_n_out == ~$past(shadow_r[6]); endproperty
   a_dir_c: assert property (p_dir_c) else $error("port c enable wrong");
   property p_pwm; $past(shadow_r[8][1])
      |-> !pc_pin_oe_n_out[1] && pc_pin_out[1] == $past(pwm_in[1]); endproperty
   a_pwm: assert property (p_pwm) else $error("pwm pin wrong");
   property p_adc; $past(shadow_r[9][3]) |-> pc_pin_oe_n_out[3]; endproperty
   a_adc: assert property (p_adc) else $error("analog pin driven");
   property p_rd_latch; take && !wb_we_in && (idx == 4'h0 || idx == 4'h2)
      |=> ((wb_dat_out[7:0] ^ shadow_r[idx]) & shadow_r[idx + 4'h4]) == 8'h00; endproperty
   a_rd_latch: assert property (p_rd_latch) else $error("output bit read wrong");
   property p_rd_b; take && !wb_we_in && idx == 4'h5 |=> wb_dat_out[7:6] == 2'h0; endproperty
   a_rd_b: assert property (p_rd_b) else $error("port b upper bits set");
   c_write: cover property (take && wb_we_in);
   c_unmapped: cover property (take && idx > 4'ha);
   c_conflict: cover property (shadow_r[8][3] && shadow_r[9][3]);
endmodule
`default_nettype wire

// ### sim/qgp_pin_model.sv
// board around the port pins: outside drivers and pull-ups
`timescale 1ns/1ps
`default_nettype none
module qgp_pin_model #(
   parameter int W = 26
) (
   input  wire logic [W-1:0] drv_in,
   input  wire logic [W-1:0] oe_n_in,
   input  wire logic [W-1:0] ext_val_in,
   input  wire logic [W-1:0] ext_en_in,
   output logic      [W-1:0] level_out
);
   // an undriven line floats to its pull-up, never to a stale level
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level_out[i] = !oe_n_in[i] ? drv_in[i] : (ext_en_in[i] ? ext_val_in[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the quad port block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_in = 1'b0, reset_n_in = 1'b0, wb_cyc_in = 1'b0, wb_stb_in = 1'b0;
   logic        wb_we_in = 1'b0, vsync_src_in = 1'b1, hsync_src_in = 1'b0;
   logic        clamp_src_in = 1'b1, sda_drive_low_in = 1'b1, scl_drive_low_in = 1'b0;
   logic        wb_ack_out, sda_level_out, scl_level_out, green_sync_level_out;
   logic [5:0]  wb_adr_in = 6'h00, pb_pin_out, pb_pin_oe_n_out;
   logic [3:0]  wb_sel_in = 4'h0, pd_pin_out, pd_pin_oe_n_out, adc_channel_select_out;
   logic [31:0] wb_dat_in = 32'h0, wb_dat_out;
   logic [7:0]  pa_pin_out, pa_pin_oe_n_out, pc_pin_out, pc_pin_oe_n_out, q, pwm_in = 8'h96;
   // serial lines pd0 and pd1 have only the pull-up outside
   logic [25:0] pin_lvl, ext_val = 26'h2e5c3a5, ext_en = 26'h33fffff;
   int          fails = 0, n_tests = 0;
   qgp_top u_qgp_top (.clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
      .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .pa_pin_in(pin_lvl[7:0]), .pa_pin_out,
      .pa_pin_oe_n_out, .pb_pin_in(pin_lvl[13:8]), .pb_pin_out, .pb_pin_oe_n_out,
      .pc_pin_in(pin_lvl[21:14]), .pc_pin_out, .pc_pin_oe_n_out, .pd_pin_in(pin_lvl[25:22]),
      .pd_pin_out, .pd_pin_oe_n_out, .pwm_in, .vsync_src_in, .hsync_src_in, .clamp_src_in,
      .sda_drive_low_in, .scl_drive_low_in, .sda_level_out, .scl_level_out,
      .adc_channel_select_out, .green_sync_level_out);
   qgp_pin_model #(.W(26)) u_qgp_pin_model (.ext_val_in(ext_val), .ext_en_in(ext_en),
      .drv_in({pd_pin_out, pc_pin_out, pb_pin_out, pa_pin_out}), .level_out(pin_lvl),
      .oe_n_in({pd_pin_oe_n_out, pc_pin_oe_n_out, pb_pin_oe_n_out, pa_pin_oe_n_out}));
   initial forever #4 clk_in = ~clk_in;
   function automatic logic [7:0] port_of(input logic [25:0] v, input int p);
      case (p)
         0: return v[7:0];
         1: return {2'h0, v[13:8]};
         2: return v[21:14];
         default: return {4'h0, v[25:22]};
      endcase
   endfunction
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wb(input logic [5:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_in);
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_sel_in <= 4'h1;
      wb_dat_in <= {24'h0, d};
      // no limit of its own: only the watchdog ends a wait for ack
      do begin
         @(posedge clk_in);
      end while (wb_ack_out !== 1'b1);
      q = wb_dat_out[7:0];
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk_in);
      reset_n_in <= 1'b1;
      for (int r = 4; r < 11; r++) begin
         wb(6'(r * 4), 1'b0, 8'h00);
         chk("cleared reg", 8'h00, q);
      end
      for (int p = 0; p < 4; p++) begin
         wb(6'(p * 4), 1'b0, 8'h00);
         chk("input read", port_of(ext_val, p), q);
         wb(6'(p * 4), 1'b1, 8'h5a);
         repeat (2) @(posedge clk_in);
         chk("pin undriven", port_of(ext_val, p), port_of(pin_lvl, p));
         wb(6'(16 + p * 4), 1'b1, 8'hff);
         wb(6'(16 + p * 4), 1'b0, 8'h00);
         chk("dir width", port_of(26'h3ffffff, p), q);
         wb(6'(16 + p * 4), 1'b1, 8'h0f);
         repeat (2) @(posedge clk_in);
         chk("pin driven", 8'h0a | port_of(ext_val, p) & 8'hf0, port_of(pin_lvl, p));
         wb(6'(p * 4), 1'b1, 8'hc3);
         wb(6'(p * 4), 1'b0, 8'h00);
         chk("mixed read", 8'h03 | port_of(ext_val, p) & 8'hf0, q);
      end
      wb(6'h30, 1'b1, 8'h77);
      wb(6'h30, 1'b0, 8'h00);
      chk("unmapped read", 8'h00, q);
      wb(6'h20, 1'b1, 8'hff);
      repeat (2) @(posedge clk_in);
      chk("pwm pins", pwm_in, port_of(pin_lvl, 2));
      pwm_in <= 8'h69;
      wb(6'h1c, 1'b1, 8'h00);
      wb(6'h24, 1'b1, 8'hff);
      wb(6'h28, 1'b1, 8'h03);
      repeat (4) @(posedge clk_in);
      chk("cfg2 wins", {2'h1, ext_val[19:16], 2'h1}, port_of(pin_lvl, 2));
      chk("adc select", 8'h0f, {4'h0, adc_channel_select_out});
      chk("serial", 8'h02, {6'h0, scl_level_out, sda_level_out});
      chk("clamp sog", 8'h03, {6'h0, pin_lvl[24], green_sync_level_out});
      reset_n_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk("reset enables", 8'hff, pa_pin_oe_n_out);
      reset_n_in <= 1'b1;
      wb(6'h10, 1'b1, 8'hff);
      wb(6'h00, 1'b0, 8'h00);
      chk("latch kept", 8'hc3, q);
      // an access off the word boundary is acked, reads zero and writes nothing
      wb(6'h11, 1'b1, 8'h00);
      wb(6'h10, 1'b0, 8'h00);
      chk("offset write", 8'hff, q);
      wb(6'h11, 1'b0, 8'h00);
      chk("offset read", 8'h00, q);
      tally_and_finish();
   end
   initial begin
      #200000;
      fails++;
      tally_and_finish();
   end
endmodule
bind qgp_top qgp_sva u_qgp_sva (.clk_in, .reset_n_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
   .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .pa_pin_oe_n_out,
   .pc_pin_out, .pc_pin_oe_n_out, .pwm_in);
`default_nettype wire
